// [rtl/pump_io_defs.svh]
/*
 Register offsets, field positions, reset values and timing figures
 of the pump remote-control block. Assumes a 25 MHz bus clock.
*/
`ifndef PUMP_IO_DEFS_SVH
`define PUMP_IO_DEFS_SVH

`define CLK_HZ 25000000
`define POWER_VALID_S 6
`define DEBOUNCE_MS 10
`define HOLD_MS 2000
`define BAUD_BPS 9600
`define BIT_CYC (`CLK_HZ / `BAUD_BPS)
`define AT_SPEED_PCT 80
`define UART_DATA_BITS 8

`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_IRQ_STAT 8'h08
`define OFF_IRQ_MASK 8'h0c
`define OFF_RATED 8'h10
`define OFF_LOWSPD 8'h14
`define OFF_TXDATA 8'h18
`define OFF_RXDATA 8'h1c

`define CTRL_ALT_BIT 0
`define CTRL_E74_BIT 1
`define CTRL_RST 2'h0
`define RATED_RST 16'hffff
`define LOWSPD_RST 16'h8000

`define REL_ROT 0
`define REL_NORM 1
`define REL_ACC 2
`define REL_BRK 3
`define REL_REM 4
`define REL_ALM 5
`define REL_WRN 6

`define EV_RESET 0
`define EV_RX 1
`define EV_TX 2
`define EV_ALARM 3
`define EV_RXOVR 4
`define EV_W 5

`endif

// [rtl/pump_io_pkg.sv]
/*
 Types of the pump remote-control block.
 Assumes nothing of its surroundings.
*/
package pump_io_pkg;
    typedef enum logic [1:0] {
        UART_IDLE = 2'b00,
        UART_START = 2'b01,
        UART_DATA = 2'b10,
        UART_STOP = 2'b11
    } uart_st_t;
endpackage

// [rtl/pump_remote_control_io.sv]
/*
 Remote-control contacts, status relays and serial port of a vacuum
 pump controller, with an AHB-Lite register slave.
 Assumes contact and pin inputs synchronous to hclk, 1 = contact closed,
 and a single slave whose hreadyout is the bus hready.
*/
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pump_io_defs.svh"

// Functional notes
// - Momentary wiring: start contact closing begins acceleration.
// - Momentary wiring: stop contact opening decelerates the pump.
// - Alternate wiring: stop contact closed runs, open stops.
// - Stop request wins over a simultaneous start request.
// - One reset event per reset contact closure.
// - Reduced-speed contact closed selects the configured low speed.
// - Rotating relay set while the rotor turns, break contact complements.
// - At-speed relay only while speed exceeds 80 % of rated.
// - Accelerating relay for the whole speed-up.
// - Decelerating relay for the whole slow-down.
// - Remote-available relay while remote commands are accepted.
// - Alarm relay while an alarm is active.
// - Warning relay while a warning is active.
// - Status outputs invalid for six seconds after power-on.
// - A setting selects alarm and warning relay behaviour; once outputs are valid, the remote relay follows remote mode.
// - Serial 9600 bps, 8 data, no parity, 1 stop, no flow control.
// - Held panel reset button toggles remote and local mode.
module pump_remote_control_io import pump_io_pkg::*; #(
    parameter int unsigned POWER_CYC = `POWER_VALID_S * `CLK_HZ,
    parameter int unsigned DEB_CYC = `DEBOUNCE_MS * (`CLK_HZ / 1000),
    parameter int unsigned HOLD_CYC = `HOLD_MS * (`CLK_HZ / 1000),
    parameter int unsigned BIT_CYC = `BIT_CYC,
    parameter int unsigned SPW = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic start_closed,
    input wire logic stop_closed,
    input wire logic reset_closed,
    input wire logic low_speed_closed,
    input wire logic panel_reset_btn,
    input wire logic [SPW-1:0] rotor_speed,
    input wire logic alarm_active,
    input wire logic warning_active,
    input wire logic rxd,
    output logic txd,
    output logic motor_run,
    output logic [SPW-1:0] speed_target,
    output logic alarm_reset,
    output logic remote_mode,
    output logic [6:0] relay_make,
    output logic [6:0] relay_break,
    output logic irq
);
    localparam int unsigned PW = $clog2(POWER_CYC + 1);
    localparam int unsigned DW = $clog2(DEB_CYC + 1);
    localparam int unsigned HW = $clog2(HOLD_CYC + 1);
    localparam int unsigned BW = $clog2(BIT_CYC + 1);
    localparam int unsigned AW = SPW + 7;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        logic ph_valid;
        logic ph_wr;
        logic [7:0] ph_addr;
        logic [1:0] ctrl;
        logic [`EV_W-1:0] irq_stat;
        logic [`EV_W-1:0] irq_mask;
        logic irq;
        logic [SPW-1:0] rated;
        logic [SPW-1:0] lowspd;
        logic [3:0] deb;
        logic [3:0][DW-1:0] deb_cnt;
        logic [HW-1:0] hold_cnt;
        logic hold_done;
        logic [PW-1:0] pwr_cnt;
        logic valid;
        logic run;
        logic remote;
        logic alarm_reset;
        logic alarm_q;
        logic [SPW-1:0] target;
        logic [6:0] make;
        logic [6:0] brk;
        uart_st_t tx_st;
        logic [BW-1:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic txd;
        uart_st_t rx_st;
        logic [BW-1:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic [7:0] rx_data;
        logic rx_valid;
    } state_t;

    state_t s_q;
    state_t s_d;

    function automatic logic [31:0] read_mux(input logic [7:0] a, input state_t s);
        logic [31:0] r;
        r = 32'h0;
        case (a)
            `OFF_CTRL: r[1:0] = s.ctrl;
            `OFF_STATUS: r[16:0] = {s.brk, s.make, s.valid, s.remote, s.run};
            `OFF_IRQ_STAT: r[`EV_W-1:0] = s.irq_stat;
            `OFF_IRQ_MASK: r[`EV_W-1:0] = s.irq_mask;
            `OFF_RATED: r[SPW-1:0] = s.rated;
            `OFF_LOWSPD: r[SPW-1:0] = s.lowspd;
            `OFF_TXDATA: r[8] = (s.tx_st != UART_IDLE);
            `OFF_RXDATA: r[8:0] = {s.rx_valid, s.rx_data};
            default: r = 32'h0;
        endcase
        return r;
    endfunction

    logic [3:0] raw;
    logic [3:0] rise;
    logic [`EV_W-1:0] ev;
    logic [`EV_W-1:0] clr;
    logic start_req;
    logic stop_req;
    logic at_speed;

    always_comb begin
        s_d = s_q;
        ev = '0;
        clr = '0;
        raw = {low_speed_closed, reset_closed, stop_closed, start_closed};
        rise = '0;
        s_d.hreadyout = 1'b1;
        s_d.hresp = 1'b0;
        s_d.alarm_reset = 1'b0;

        // Contact debounce
        for (int i = 0; i < 4; i++) begin
            if (raw[i] == s_q.deb[i]) begin
                s_d.deb_cnt[i] = '0;
            end else if (s_q.deb_cnt[i] == DW'(DEB_CYC - 1)) begin
                s_d.deb_cnt[i] = '0;
                s_d.deb[i] = raw[i];
                rise[i] = raw[i];
            end else begin
                s_d.deb_cnt[i] = s_q.deb_cnt[i] + 1'b1;
            end
        end

        // Panel button hold toggles mode once per press
        if (!panel_reset_btn) begin
            s_d.hold_cnt = '0;
            s_d.hold_done = 1'b0;
        end else if (!s_q.hold_done) begin
            if (s_q.hold_cnt == HW'(HOLD_CYC - 1)) begin
                s_d.hold_done = 1'b1;
                s_d.remote = !s_q.remote;
            end else begin
                s_d.hold_cnt = s_q.hold_cnt + 1'b1;
            end
        end

        // Run command
        if (s_q.ctrl[`CTRL_ALT_BIT]) begin
            start_req = s_q.deb[1];
            stop_req = !s_q.deb[1];
        end else begin
            start_req = rise[0];
            stop_req = !s_q.deb[1];
        end
        if (s_q.remote) begin
            if (stop_req) begin
                s_d.run = 1'b0;
            end else if (start_req) begin
                s_d.run = 1'b1;
            end
            if (rise[2]) begin
                s_d.alarm_reset = 1'b1;
                ev[`EV_RESET] = 1'b1;
            end
        end
        s_d.target = s_q.deb[3] ? s_q.lowspd : s_q.rated;

        // Power-on invalid interval
        if (!s_q.valid) begin
            if (s_q.pwr_cnt == PW'(POWER_CYC - 1)) begin
                s_d.valid = 1'b1;
            end else begin
                s_d.pwr_cnt = s_q.pwr_cnt + 1'b1;
            end
        end

        // Status relays
        at_speed = (AW'(rotor_speed) * AW'(100)) > (AW'(s_q.rated) * AW'(`AT_SPEED_PCT));
        s_d.make[`REL_ROT] = rotor_speed != '0;
        s_d.make[`REL_NORM] = at_speed;
        s_d.make[`REL_ACC] = s_q.run && rotor_speed < s_q.target;
        s_d.make[`REL_BRK] = rotor_speed != '0 && (!s_q.run || rotor_speed > s_q.target);
        s_d.make[`REL_REM] = s_q.remote;
        if (s_q.ctrl[`CTRL_E74_BIT]) begin
            s_d.make[`REL_ALM] = !alarm_active;
            s_d.make[`REL_WRN] = !warning_active;
        end else begin
            s_d.make[`REL_ALM] = alarm_active;
            s_d.make[`REL_WRN] = warning_active;
        end
        if (!s_q.valid) begin
            s_d.make = '0;
        end
        s_d.brk = ~s_d.make;
        s_d.alarm_q = alarm_active;
        ev[`EV_ALARM] = alarm_active && !s_q.alarm_q;

        // Serial transmitter
        case (s_q.tx_st)
            UART_IDLE: begin
                s_d.txd = 1'b1;
            end
            UART_START, UART_DATA, UART_STOP: begin
                if (s_q.tx_cnt == BW'(BIT_CYC - 1)) begin
                    s_d.tx_cnt = '0;
                    if (s_q.tx_st == UART_START) begin
                        s_d.tx_st = UART_DATA;
                        s_d.txd = s_q.tx_sh[0];
                    end else if (s_q.tx_st == UART_DATA) begin
                        s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
                        s_d.tx_bit = s_q.tx_bit + 1'b1;
                        if (s_q.tx_bit == 3'(`UART_DATA_BITS - 1)) begin
                            s_d.tx_st = UART_STOP;
                            s_d.txd = 1'b1;
                        end else begin
                            s_d.txd = s_q.tx_sh[1];
                        end
                    end else begin
                        s_d.tx_st = UART_IDLE;
                        ev[`EV_TX] = 1'b1;
                    end
                end else begin
                    s_d.tx_cnt = s_q.tx_cnt + 1'b1;
                end
            end
            default: s_d.tx_st = UART_IDLE;
        endcase

        // Serial receiver
        case (s_q.rx_st)
            UART_IDLE: begin
                if (!rxd) begin
                    s_d.rx_st = UART_START;
                    s_d.rx_cnt = '0;
                end
            end
            UART_START: begin
                if (s_q.rx_cnt == BW'(BIT_CYC / 2 - 1)) begin
                    s_d.rx_cnt = '0;
                    s_d.rx_bit = '0;
                    s_d.rx_st = rxd ? UART_IDLE : UART_DATA;
                end else begin
                    s_d.rx_cnt = s_q.rx_cnt + 1'b1;
                end
            end
            UART_DATA: begin
                if (s_q.rx_cnt == BW'(BIT_CYC - 1)) begin
                    s_d.rx_cnt = '0;
                    s_d.rx_sh = {rxd, s_q.rx_sh[7:1]};
                    s_d.rx_bit = s_q.rx_bit + 1'b1;
                    if (s_q.rx_bit == 3'(`UART_DATA_BITS - 1)) begin
                        s_d.rx_st = UART_STOP;
                    end
                end else begin
                    s_d.rx_cnt = s_q.rx_cnt + 1'b1;
                end
            end
            UART_STOP: begin
                if (s_q.rx_cnt == BW'(BIT_CYC - 1)) begin
                    s_d.rx_cnt = '0;
                    s_d.rx_st = UART_IDLE;
                    if (rxd) begin
                        ev[`EV_RX] = 1'b1;
                        ev[`EV_RXOVR] = s_q.rx_valid;
                        s_d.rx_data = s_q.rx_sh;
                    end
                end else begin
                    s_d.rx_cnt = s_q.rx_cnt + 1'b1;
                end
            end
            default: s_d.rx_st = UART_IDLE;
        endcase

        // Bus data phase: writes
        if (s_q.ph_valid && s_q.ph_wr) begin
            case (s_q.ph_addr)
                `OFF_CTRL: s_d.ctrl = hwdata[1:0];
                `OFF_IRQ_STAT: clr = hwdata[`EV_W-1:0];
                `OFF_IRQ_MASK: s_d.irq_mask = hwdata[`EV_W-1:0];
                `OFF_RATED: s_d.rated = hwdata[SPW-1:0];
                `OFF_LOWSPD: s_d.lowspd = hwdata[SPW-1:0];
                `OFF_TXDATA: begin
                    if (s_q.tx_st == UART_IDLE) begin
                        s_d.tx_sh = hwdata[7:0];
                        s_d.tx_st = UART_START;
                        s_d.tx_cnt = '0;
                        s_d.tx_bit = '0;
                        s_d.txd = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Bus address phase: capture and read data
        s_d.ph_valid = 1'b0;
        if (hsel && htrans[1] && hready) begin
            s_d.ph_valid = 1'b1;
            s_d.ph_wr = hwrite;
            s_d.ph_addr = {haddr[7:2], 2'b00};
            s_d.hrdata = hwrite ? 32'h0 : read_mux({haddr[7:2], 2'b00}, s_q);
            if (!hwrite && {haddr[7:2], 2'b00} == `OFF_RXDATA) begin
                s_d.rx_valid = 1'b0;
            end
        end
        if (ev[`EV_RX]) begin
            s_d.rx_valid = 1'b1;
        end

        // Interrupts: set wins over clear
        s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.hreadyout <= 1'b1;
            s_q.ctrl <= `CTRL_RST;
            s_q.rated <= `RATED_RST;
            s_q.lowspd <= `LOWSPD_RST;
            s_q.deb[1] <= 1'b0;
            s_q.remote <= 1'b1;
            s_q.brk <= 7'h7f;
            s_q.tx_st <= UART_IDLE;
            s_q.rx_st <= UART_IDLE;
            s_q.txd <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign hreadyout = s_q.hreadyout;
    assign hresp = s_q.hresp;
    assign hrdata = s_q.hrdata;
    assign txd = s_q.txd;
    assign motor_run = s_q.run;
    assign speed_target = s_q.target;
    assign alarm_reset = s_q.alarm_reset;
    assign remote_mode = s_q.remote;
    assign relay_make = s_q.make;
    assign relay_break = s_q.brk;
    assign irq = s_q.irq;
endmodule

// [verification/host_uart.sv]
/* Serial host on the far side of the pump serial port.
   Assumes the bit time in hclk cycles matches the block. */
`timescale 1ns/1ps
module host_uart #(parameter int BIT_CYC = 16) (
    input wire logic hclk,
    input wire logic txd,
    output logic rxd
);
    logic [7:0] got = 8'h00;
    int n_got = 0;
    initial rxd = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (BIT_CYC) @(posedge hclk);
        end
    endtask
    always begin
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge hclk);
            got[i] = txd;
        end
        repeat (BIT_CYC) @(posedge hclk);
        if (txd === 1'b1) n_got++;
    end
endmodule

// [verification/pump_remote_control_io_chk.sv]
/* Port assertions of the pump remote-control block.
   Bound to every instance of the block; sees its ports only. */
`timescale 1ns/1ps
module pump_remote_control_io_chk #(
    parameter int unsigned POWER_CYC = 50,
    parameter int unsigned DEB_CYC = 4,
    parameter int unsigned SPW = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic stop_closed,
    input wire logic panel_reset_btn,
    input wire logic [SPW-1:0] rotor_speed,
    input wire logic alarm_active,
    input wire logic warning_active,
    input wire logic txd,
    input wire logic motor_run,
    input wire logic [SPW-1:0] speed_target,
    input wire logic alarm_reset,
    input wire logic remote_mode,
    input wire logic [6:0] relay_make,
    input wire logic [6:0] relay_break
);
    int unsigned age_q;
    logic [3:0] open_q;
    logic ok;
    assign ok = (age_q == POWER_CYC + 2);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            age_q <= 0;
            open_q <= 4'h0;
        end else begin
            age_q <= (age_q < POWER_CYC + 2) ? age_q + 1 : age_q;
            open_q <= stop_closed ? 4'h0 : ((open_q == 4'hf) ? open_q : open_q + 4'h1);
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_pulse_gap;
        ##1 !alarm_reset [*7];
    endsequence
    sequence s_start_bit;
        ##1 !txd [*8];
    endsequence
    a_break_compl: assert property (relay_break == ~relay_make) else $error("break not complement");
    a_power_hold: assert property (age_q + 1 < POWER_CYC |-> relay_make == 7'h00) else $error("early relay");
    a_rot_relay: assert property (ok |-> relay_make[0] == ($past(rotor_speed) != 0)) else $error("rotating");
    a_accel_relay: assert property (ok |-> relay_make[2] == $past(motor_run && rotor_speed < speed_target))
        else $error("accelerating");
    a_decel_relay: assert property (ok |->
        relay_make[3] == $past(rotor_speed != 0 && (!motor_run || rotor_speed > speed_target)))
        else $error("decelerating");
    a_alarm_warn: assert property (ok |-> (relay_make[5] ^ $past(alarm_active)) ==
        (relay_make[6] ^ $past(warning_active))) else $error("alarm warning mode");
    a_stop_wins: assert property (open_q > DEB_CYC + 3 && remote_mode |-> !motor_run)
        else $error("runs with stop open");
    a_reset_once: assert property (alarm_reset |-> remote_mode and s_pulse_gap) else $error("reset pulse");
    a_remote_run: assert property ($rose(motor_run) |-> remote_mode) else $error("start in local");
    a_mode_button: assert property ($changed(remote_mode) |-> $past(panel_reset_btn)) else $error("mode");
    a_tx_start: assert property ($fell(txd) |-> s_start_bit) else $error("start bit short");
endmodule
bind pump_remote_control_io pump_remote_control_io_chk #(.POWER_CYC(POWER_CYC), .DEB_CYC(DEB_CYC), .SPW(SPW)) chk_i (
    .hclk(hclk), .hresetn(hresetn), .stop_closed(stop_closed), .panel_reset_btn(panel_reset_btn),
    .rotor_speed(rotor_speed), .alarm_active(alarm_active), .warning_active(warning_active), .txd(txd),
    .motor_run(motor_run), .speed_target(speed_target), .alarm_reset(alarm_reset),
    .remote_mode(remote_mode), .relay_make(relay_make), .relay_break(relay_break));

// [verification/pump_remote_control_io_tb_top.sv]
/* Self-checking bench of the pump remote-control block.
   Drives AHB-Lite, contacts and the serial host model. */
`timescale 1ns/1ps
`include "pump_io_defs.svh"
module pump_remote_control_io_tb_top;
    localparam int DEB = 4;
    logic hclk, hresetn, hsel, hwrite, txd, rxd, hreadyout, hresp, motor_run, alarm_reset, remote_mode, irq;
    logic start_closed, stop_closed, reset_closed, low_speed_closed, panel_reset_btn, alarm_active, warning_active;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] rotor_speed, speed_target, v;
    logic [15:0] sp [3] = '{16'hcccc, 16'hcccd, 16'h0001};
    logic [6:0] relay_make, relay_break;
    int mismatches = 0;
    int compares = 0;
    int pulses = 0;
    pump_remote_control_io #(.POWER_CYC(50), .DEB_CYC(DEB), .HOLD_CYC(20), .BIT_CYC(16)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .start_closed(start_closed), .stop_closed(stop_closed), .reset_closed(reset_closed),
        .low_speed_closed(low_speed_closed), .panel_reset_btn(panel_reset_btn), .rotor_speed(rotor_speed),
        .alarm_active(alarm_active), .warning_active(warning_active), .rxd(rxd), .txd(txd),
        .motor_run(motor_run), .speed_target(speed_target), .alarm_reset(alarm_reset),
        .remote_mode(remote_mode), .relay_make(relay_make), .relay_break(relay_break), .irq(irq));
    host_uart #(.BIT_CYC(16)) host (.hclk(hclk), .txd(txd), .rxd(rxd));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) if (alarm_reset === 1'b1) pulses++;
    task automatic test_done;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 20);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 40);
        rd = hrdata;
        if (n >= 20) begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    function automatic logic at_speed(input logic [15:0] s, input logic [15:0] r);
        return s * 100 > r * 80;
    endfunction
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, rotor_speed} = '0;
        {start_closed, stop_closed, reset_closed, low_speed_closed, panel_reset_btn} = '0;
        {alarm_active, warning_active} = '0;
        hsize = 3'b010;
        v = 16'($urandom(32'h2192));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        wt(1);
        chk(relay_make, 0, "invalid");
        ahb(0, 8'h20, 0);
        chk(rd, 0, "unmapped");
        chk(hresp, 0, "okay");
        wt(60);
        ahb(0, `OFF_STATUS, 0);
        chk(rd[2], 1, "valid");
        $display("test reset done");
        stop_closed <= 1'b1;
        wt(DEB + 4);
        start_closed <= 1'b1;
        wt(DEB + 4);
        chk(motor_run, 1, "start");
        sp[2] = 16'($urandom_range(16'hfffe, 1));
        foreach (sp[i]) begin
            rotor_speed <= sp[i];
            wt(3);
            chk(relay_make[1], at_speed(sp[i], 16'hffff), "at speed");
            chk(relay_make[2], 1, "accel");
            chk(relay_make[0], 1, "rotating");
        end
        stop_closed <= 1'b0;
        wt(DEB + 4);
        chk(motor_run, 0, "stop wins");
        chk(relay_make[3], 1, "decel");
        start_closed <= 1'b0;
        wt(DEB + 4);
        start_closed <= 1'b1;
        repeat (DEB + 4) begin
            wt(1);
            chk(motor_run, 0, "start under stop");
        end
        start_closed <= 1'b0;
        $display("test momentary done");
        v = 16'($urandom);
        ahb(1, `OFF_LOWSPD, {16'h0, v});
        low_speed_closed <= 1'b1;
        wt(DEB + 4);
        chk(speed_target, v, "low speed");
        low_speed_closed <= 1'b0;
        ahb(1, `OFF_CTRL, 1);
        stop_closed <= 1'b1;
        wt(DEB + 4);
        chk(motor_run, 1, "alt run");
        stop_closed <= 1'b0;
        wt(DEB + 4);
        chk(motor_run, 0, "alt stop");
        ahb(1, `OFF_CTRL, 0);
        $display("test wiring done");
        ahb(1, `OFF_IRQ_MASK, 1);
        pulses = 0;
        repeat (3) begin
            reset_closed <= 1'b1;
            wt(2);
            reset_closed <= 1'b0;
            wt(2);
        end
        reset_closed <= 1'b1;
        wt(DEB + 6);
        reset_closed <= 1'b0;
        wt(DEB + 4);
        chk(pulses, 1, "one reset");
        chk(irq, 1, "irq set");
        ahb(1, `OFF_IRQ_STAT, 1);
        wt(2);
        chk(irq, 0, "irq clear");
        $display("test reset contact done");
        alarm_active <= 1'b1;
        wt(3);
        chk(relay_make[6:5], 2'b01, "alarm");
        ahb(1, `OFF_CTRL, 2);
        alarm_active <= 1'b0;
        warning_active <= 1'b1;
        wt(3);
        chk(relay_make[6:5], 2'b01, "e74");
        ahb(1, `OFF_CTRL, 0);
        wt(3);
        chk(relay_make[6:5], 2'b10, "warning");
        warning_active <= 1'b0;
        $display("test relays done");
        v = 16'($urandom);
        ahb(1, `OFF_TXDATA, {24'h0, v[7:0]});
        for (int n = 0; n < 400 && host.n_got == 0; n++) wt(1);
        chk(host.n_got, 1, "tx frame");
        chk(host.got, v[7:0], "tx byte");
        v = 16'($urandom);
        host.send(v[7:0]);
        wt(4);
        ahb(0, `OFF_RXDATA, 0);
        chk(rd[8:0], {1'b1, v[7:0]}, "rx byte");
        $display("test serial done");
        panel_reset_btn <= 1'b1;
        wt(30);
        panel_reset_btn <= 1'b0;
        wt(4);
        chk(remote_mode, 0, "local");
        chk(relay_make[4], 0, "remote relay");
        stop_closed <= 1'b1;
        wt(DEB + 4);
        start_closed <= 1'b1;
        wt(DEB + 4);
        chk(motor_run, 0, "local ignores");
        start_closed <= 1'b0;
        panel_reset_btn <= 1'b1;
        wt(30);
        panel_reset_btn <= 1'b0;
        wt(4);
        chk(remote_mode, 1, "remote");
        chk(relay_make[4], 1, "remote relay on");
        $display("test mode done");
        test_done();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        test_done();
    end
endmodule
